// ### inc/debug_access_pkg.sv
package debug_access_pkg;
   // link timing, host makes the link clock by dividing clk_sys
   localparam int         SYS_PERIOD_NS  = 50;
   localparam int         LINK_PERIOD_NS = 800;
   localparam logic [3:0] LINK_HALF_CYC  = 4'(LINK_PERIOD_NS / SYS_PERIOD_NS / 2);
   // slot numbers within one frame
   localparam logic [5:0] SLOT_REQ_LAST = 6'h07;
   localparam logic [5:0] SLOT_TURN     = 6'h08;
   localparam logic [5:0] SLOT_ACK0     = 6'h09;
   localparam logic [5:0] SLOT_ACK_LAST = 6'h0B;
   localparam logic [5:0] SLOT_RD0      = 6'h0C;
   localparam logic [5:0] SLOT_RD_PAR   = 6'h2C;
   localparam logic [5:0] SLOT_WR0      = 6'h0D;
   localparam logic [5:0] SLOT_WR_LAST  = 6'h2C;
   localparam logic [5:0] SLOT_WR_PAR   = 6'h2D;
   localparam logic [5:0] SLOT_END      = 6'h2E;
   localparam logic [2:0] ACK_OK        = 3'h1;
   localparam logic [2:0] ACK_FAULT     = 3'h4;
   // request word bit positions, sent from bit 0
   localparam int         REQ_PORT = 1;
   localparam int         REQ_READ = 2;
   localparam int         REQ_A2   = 3;
   localparam int         REQ_A3   = 4;
   localparam int         REQ_PAR  = 5;
   localparam int         REQ_STOP = 6;
   localparam int         REQ_PARK = 7;
   // front register index from A[3:2]
   localparam logic [1:0] IDX_ID_ABORT = 2'h0;
   localparam logic [1:0] IDX_CTRL     = 2'h1;
   localparam logic [1:0] IDX_BANK     = 2'h2;
   localparam logic [1:0] IDX_LAST_RD  = 2'h3;
   // bank choice register fields
   localparam int         PNUM_LSB   = 24;
   localparam int         PBANK_LSB  = 4;
   localparam int         FBANK_LSB  = 0;
   localparam logic [31:0] BANK_RST  = 32'h0000_0000;
   localparam int         ABORT_CLR  = 0;
   // sticky flags
   localparam int         STK_W      = 3;
   localparam int         STK_REQ    = 0;
   localparam int         STK_WDATA  = 1;
   localparam int         STK_PORT   = 2;
   // resource ports
   localparam int         NUM_PORTS  = 2;
   localparam logic [3:0] ID_WORD    = 4'hF;
   localparam logic [31:0] FRONT_ID_CODE = 32'h1357_0001; // arbitrary value
   localparam logic [31:0] PORT_ID_BASE  = 32'h2468_0000; // arbitrary value
   // host wishbone map
   localparam logic [7:0] WB_CMD      = 8'h00;
   localparam logic [7:0] WB_WDATA    = 8'h04;
   localparam logic [7:0] WB_RDATA    = 8'h08;
   localparam logic [7:0] WB_STATUS   = 8'h0C;
   localparam logic [7:0] WB_IRQ_STAT = 8'h10;
   localparam logic [7:0] WB_IRQ_MASK = 8'h14;
   localparam int         CMD_PORT    = 0;
   localparam int         CMD_READ    = 1;
   localparam int         CMD_A_LSB   = 2;
   localparam int         IRQ_W       = 3;
   localparam int         IRQ_DONE    = 0;
   localparam int         IRQ_FAULT   = 1;
   localparam int         IRQ_PARITY  = 2;
   localparam logic [2:0] IRQ_MASK_RST = 3'h0;
endpackage : debug_access_pkg

// ### inc/two_wire_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface two_wire_link_if;
   logic linkClk;    // made by the host end
   logic dioHost;    // host drive value
   logic dioHostOeN; // host drives while low
   logic dioDev;     // device drive value
   logic dioDevOeN;  // device drives while low
   logic dio;        // resolved data wire, pulled low when undriven
   assign dio = !dioHostOeN ? dioHost : (!dioDevOeN ? dioDev : 1'b0);
   modport host (output linkClk, output dioHost, output dioHostOeN, input dio);
   modport dev (input linkClk, input dio, output dioDev, output dioDevOeN);
endinterface : two_wire_link_if
`default_nettype wire

// ### core/two_wire_front_port.sv
`timescale 1ns/1ps
`default_nettype none
module two_wire_front_port
(
   input  wire logic                           clk_sys,     // system clock
   input  wire logic                           rstn,        // async reset, low
   two_wire_link_if.dev                        link,        // two-pin link
   output logic                                portWrStb,   // port word written
   output logic [7:0]                          portWrSel,   // port number written
   output logic [7:0]                          portWrAddr,  // byte address in port
   output logic [31:0]                         portWrData,  // word written
   output logic [debug_access_pkg::STK_W-1:0]  stickyFlags  // sticky outcome flags
);
   import debug_access_pkg::*;
   typedef enum logic {ST_IDLE, ST_FRAME} state_t;
   state_t            state_reg;
   logic [5:0]        slot_reg;
   logic [2:0]        clkSync_reg;
   logic [1:0]        dioSync_reg;
   logic [7:0]        req_reg;
   logic [31:0]       rdShift_reg;
   logic              rdPar_reg;
   logic [31:0]       wdShift_reg;
   logic [31:0]       bank_reg;
   logic [31:0]       lastRd_reg;
   logic [STK_W-1:0]  sticky_reg;
   logic              dioOut_reg;
   logic              dioOeN_reg;
   logic              linkRise;
   logic              dioIn;
   logic              inFrame;
   logic              reqOk;
   logic              isPort;
   logic              isRead;
   logic [1:0]        addrA;
   logic [2:0]        ackCode;
   logic [7:0]        portSel;
   logic [7:0]        portAddr;
   logic              portValid;
   logic [31:0]       readWord;
   logic              wrCommit;
   logic              wrParOk;
   logic [STK_W-1:0]  stkSet;
   logic [STK_W-1:0]  stkClr;
   logic [31:0]       portRd [NUM_PORTS];
   // clock and data pins are sampled by clk_sys
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         clkSync_reg <= 3'h0;
         dioSync_reg <= 2'h0;
      end
      else
      begin
         clkSync_reg <= {clkSync_reg[1:0], link.linkClk};
         dioSync_reg <= {dioSync_reg[0], link.dio};
      end
   end
   assign linkRise = clkSync_reg[1] & ~clkSync_reg[2];
   assign dioIn    = dioSync_reg[1];
   assign inFrame  = linkRise && (state_reg == ST_FRAME);
   // request decode
   assign isPort  = req_reg[REQ_PORT];
   assign isRead  = req_reg[REQ_READ];
   assign addrA   = {req_reg[REQ_A3], req_reg[REQ_A2]};
   assign reqOk   = (req_reg[REQ_PAR] == ^req_reg[REQ_A3:REQ_PORT])
                    && !req_reg[REQ_STOP] && req_reg[REQ_PARK];
   assign ackCode = reqOk ? ACK_OK : ACK_FAULT;
   assign portSel   = bank_reg[PNUM_LSB +: 8];
   assign portAddr  = {bank_reg[PBANK_LSB +: 4], addrA, 2'b00};
   assign portValid = portSel < 8'(NUM_PORTS);
   assign wrParOk   = (dioIn == ^wdShift_reg);
   assign wrCommit  = inFrame && (slot_reg == SLOT_WR_PAR) && reqOk && !isRead && wrParOk;
   // one storage block per resource port
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PORTS; gi++)
      begin : g_port
         logic [31:0] words [16];
         always_ff @(posedge clk_sys)
         begin
            if (wrCommit && isPort && portSel == 8'(gi) && portAddr[7:2] != {ID_WORD, 2'h3})
               words[portAddr[5:2]] <= wdShift_reg;
         end
         // identification word at the top of the last bank
         assign portRd[gi] = (portAddr[7:2] == {ID_WORD, 2'h3})
                             ? (PORT_ID_BASE | 32'(gi)) : words[portAddr[5:2]];
      end
   endgenerate
   // read word chosen at the turnaround slot
   always_comb
   begin
      readWord = 32'h0000_0000;
      if (isPort)
      begin
         if (portValid)
            readWord = portRd[portSel[0 +: $clog2(NUM_PORTS)]];
      end
      else if (addrA == IDX_ID_ABORT)
         readWord = FRONT_ID_CODE;
      else if (addrA == IDX_CTRL)
         readWord = (bank_reg[FBANK_LSB +: 4] == 4'h0)
                    ? 32'(sticky_reg) : 32'h0000_0000;
      else if (addrA == IDX_BANK)
         readWord = bank_reg;
      else
         readWord = lastRd_reg;
   end
   // frame sequencing on link clock rises
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         state_reg <= ST_IDLE;
         slot_reg  <= 6'h00;
      end
      else if (linkRise)
      begin
         case (state_reg)
            ST_IDLE:
            begin
               if (dioIn)
               begin
                  state_reg <= ST_FRAME;
                  slot_reg  <= 6'h01;
               end
            end
            ST_FRAME:
            begin
               slot_reg <= slot_reg + 6'h01;
               if ((slot_reg == SLOT_ACK_LAST && !reqOk)
                   || (slot_reg == SLOT_RD_PAR && isRead)
                   || slot_reg == SLOT_WR_PAR)
                  state_reg <= ST_IDLE;
            end
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end
   // request and write data capture
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         req_reg     <= 8'h00;
         wdShift_reg <= 32'h0000_0000;
      end
      else if (linkRise && state_reg == ST_IDLE && dioIn)
         req_reg <= 8'h01;
      else if (inFrame && slot_reg <= SLOT_REQ_LAST)
         req_reg[slot_reg[2:0]] <= dioIn;
      else if (inFrame && slot_reg >= SLOT_WR0 && slot_reg <= SLOT_WR_LAST && !isRead)
         wdShift_reg <= {dioIn, wdShift_reg[31:1]};
   end
   // pin drive: ack, then read data, parity, release
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         dioOut_reg  <= 1'b0;
         dioOeN_reg  <= 1'b1;
         rdShift_reg <= 32'h0000_0000;
         rdPar_reg   <= 1'b0;
      end
      else if (inFrame)
      begin
         if (slot_reg == SLOT_TURN)
         begin
            dioOeN_reg  <= 1'b0;
            dioOut_reg  <= ackCode[0];
            rdShift_reg <= readWord;
            rdPar_reg   <= ^readWord;
         end
         else if (slot_reg > SLOT_TURN && slot_reg < SLOT_ACK_LAST)
            dioOut_reg <= ackCode[slot_reg[1:0] - 2'h0];
         else if (slot_reg >= SLOT_ACK_LAST && slot_reg < SLOT_RD_PAR - 6'h01
                  && isRead && reqOk)
         begin
            dioOut_reg  <= rdShift_reg[0];
            rdShift_reg <= {1'b0, rdShift_reg[31:1]};
         end
         else if (slot_reg == SLOT_RD_PAR - 6'h01 && isRead && reqOk)
            dioOut_reg <= rdPar_reg;
         else if (slot_reg >= SLOT_ACK_LAST)
            dioOeN_reg <= 1'b1;
      end
   end
   // register updates and sticky flags
   always_comb
   begin
      stkSet = '0;
      stkClr = '0;
      if (inFrame && slot_reg == SLOT_TURN)
      begin
         stkSet[STK_REQ]  = !reqOk;
         stkSet[STK_PORT] = reqOk && isPort && isRead && !portValid;
      end
      if (inFrame && slot_reg == SLOT_WR_PAR && reqOk && !isRead)
      begin
         stkSet[STK_WDATA] = !wrParOk;
         stkSet[STK_PORT]  = wrParOk && isPort && !portValid;
      end
      if (wrCommit && !isPort && addrA == IDX_ID_ABORT && wdShift_reg[ABORT_CLR])
         stkClr = '1;
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         sticky_reg <= '0;
         bank_reg   <= BANK_RST;
         lastRd_reg <= 32'h0000_0000;
      end
      else
      begin
         sticky_reg <= (sticky_reg & ~stkClr) | stkSet;
         if (wrCommit && !isPort && addrA == IDX_BANK)
            bank_reg <= wdShift_reg;
         if (inFrame && slot_reg == SLOT_TURN && reqOk && isRead && isPort)
            lastRd_reg <= readWord;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         portWrStb  <= 1'b0;
         portWrSel  <= 8'h00;
         portWrAddr <= 8'h00;
         portWrData <= 32'h0000_0000;
      end
      else
      begin
         portWrStb <= wrCommit && isPort && portValid;
         if (wrCommit && isPort && portValid)
         begin
            portWrSel  <= portSel;
            portWrAddr <= portAddr;
            portWrData <= wdShift_reg;
         end
      end
   end
   // one front port on two pins; the serial protocol is the only one
   assign link.dioDev    = dioOut_reg;
   assign link.dioDevOeN = dioOeN_reg;
   assign stickyFlags    = sticky_reg;
endmodule : two_wire_front_port
`default_nettype wire

// ### core/two_wire_host_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module two_wire_host_ctrl
(
   input  wire logic         clk_sys,   // system clock
   input  wire logic         rstn,      // async reset, low
   input  wire logic         wb_cyc_i,  // wishbone cycle
   input  wire logic         wb_stb_i,  // wishbone strobe
   input  wire logic         wb_we_i,   // wishbone write
   input  wire logic [7:0]   wb_adr_i,  // wishbone byte address
   input  wire logic [3:0]   wb_sel_i,  // wishbone byte lanes
   input  wire logic [31:0]  wb_dat_i,  // wishbone write data
   output logic [31:0]       wb_dat_o,  // wishbone read data
   output logic              wb_ack_o,  // wishbone ack
   output logic              irq,       // level interrupt
   two_wire_link_if.host     link       // two-pin link
);
   import debug_access_pkg::*;

   typedef enum logic {H_IDLE, H_RUN} hstate_t;

   hstate_t           state_reg;
   logic [3:0]        div_reg;
   logic              clk_reg;
   logic [5:0]        fIdx_reg;
   logic [1:0]        dioSync_reg;
   logic [7:0]        req_reg;
   logic [31:0]       wd_reg;
   logic [31:0]       wdShift_reg;
   logic [31:0]       rd_reg;
   logic [2:0]        ack_reg;
   logic              parErr_reg;
   logic              out_reg;
   logic              oeN_reg;
   logic [IRQ_W-1:0]  irqStat_reg;
   logic [IRQ_W-1:0]  irqMask_reg;
   logic [IRQ_W-1:0]  irqSet;
   logic              ack_reg_o;
   logic              fallEv;
   logic              riseEv;
   logic              wbDo;
   logic              dioIn;
   logic [5:0]        sIdx;

   // link clock divider
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         div_reg <= 4'h0;
         clk_reg <= 1'b0;
      end
      else if (div_reg == LINK_HALF_CYC - 4'h1)
      begin
         div_reg <= 4'h0;
         clk_reg <= ~clk_reg;
      end
      else
         div_reg <= div_reg + 4'h1;
   end
   assign riseEv = (div_reg == LINK_HALF_CYC - 4'h1) && !clk_reg;
   assign fallEv = (div_reg == LINK_HALF_CYC - 4'h1) && clk_reg;

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         dioSync_reg <= 2'h0;
      else
         dioSync_reg <= {dioSync_reg[0], link.dio};
   end
   assign dioIn = dioSync_reg[1];
   assign sIdx  = fIdx_reg - 6'h01;
   assign wbDo  = wb_cyc_i && wb_stb_i && ack_reg_o;

   // frame drive on falls, sampling on rises
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         state_reg   <= H_IDLE;
         fIdx_reg    <= 6'h00;
         out_reg     <= 1'b0;
         oeN_reg     <= 1'b0;
         req_reg     <= 8'h00;
         wd_reg      <= 32'h0000_0000;
         wdShift_reg <= 32'h0000_0000;
         rd_reg      <= 32'h0000_0000;
         ack_reg     <= 3'h0;
         parErr_reg  <= 1'b0;
      end
      else
      begin
         case (state_reg)
            H_IDLE:
            begin
               if (wbDo && wb_we_i && wb_adr_i == WB_WDATA)
                  wd_reg <= wb_dat_i;
               if (wbDo && wb_we_i && wb_adr_i == WB_CMD)
               begin
                  req_reg <= {1'b1, 1'b0, ^wb_dat_i[CMD_A_LSB +: 2] ^ wb_dat_i[CMD_READ]
                              ^ wb_dat_i[CMD_PORT], wb_dat_i[CMD_A_LSB +: 2],
                              wb_dat_i[CMD_READ], wb_dat_i[CMD_PORT], 1'b1};
                  wdShift_reg <= wd_reg;
                  fIdx_reg    <= 6'h00;
                  parErr_reg  <= 1'b0;
                  state_reg   <= H_RUN;
               end
            end
            H_RUN:
            begin
               if (fallEv)
               begin
                  fIdx_reg <= fIdx_reg + 6'h01;
                  if (fIdx_reg <= SLOT_REQ_LAST)
                     out_reg <= req_reg[fIdx_reg[2:0]];
                  else if (fIdx_reg == SLOT_TURN)
                     oeN_reg <= 1'b1;
                  else if ((fIdx_reg == SLOT_RD0 && ack_reg != ACK_OK) || fIdx_reg == SLOT_END)
                  begin
                     out_reg   <= 1'b0;
                     oeN_reg   <= 1'b0;
                     state_reg <= H_IDLE;
                  end
                  else if (fIdx_reg >= SLOT_WR0 && fIdx_reg <= SLOT_WR_LAST && !req_reg[REQ_READ])
                  begin
                     oeN_reg     <= 1'b0;
                     out_reg     <= wdShift_reg[0];
                     wdShift_reg <= {1'b0, wdShift_reg[31:1]};
                  end
                  else if (fIdx_reg == SLOT_WR_PAR && !req_reg[REQ_READ])
                     out_reg <= ^wd_reg;
               end
               if (riseEv && fIdx_reg != 6'h00)
               begin
                  if (sIdx >= SLOT_ACK0 && sIdx <= SLOT_ACK_LAST)
                     ack_reg <= {dioIn, ack_reg[2:1]};
                  else if (sIdx >= SLOT_RD0 && sIdx < SLOT_RD_PAR && req_reg[REQ_READ])
                     rd_reg <= {dioIn, rd_reg[31:1]};
                  else if (sIdx == SLOT_RD_PAR && req_reg[REQ_READ])
                     parErr_reg <= (dioIn != ^rd_reg);
               end
            end
            default:
               state_reg <= H_IDLE;
         endcase
      end
   end

   // frame-end events
   always_comb
   begin
      irqSet = '0;
      if (state_reg == H_RUN && fallEv
          && ((fIdx_reg == SLOT_RD0 && ack_reg != ACK_OK) || fIdx_reg == SLOT_END))
      begin
         irqSet[IRQ_DONE]   = 1'b1;
         irqSet[IRQ_FAULT]  = (ack_reg != ACK_OK);
         irqSet[IRQ_PARITY] = parErr_reg;
      end
   end

   // wishbone slave, one wait state, then ack for one cycle
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         ack_reg_o   <= 1'b0;
         wb_dat_o    <= 32'h0000_0000;
         irqStat_reg <= '0;
         irqMask_reg <= IRQ_MASK_RST;
      end
      else
      begin
         ack_reg_o <= wb_cyc_i && wb_stb_i && !ack_reg_o;
         if (wb_cyc_i && wb_stb_i && !ack_reg_o)
         begin
            if (wb_adr_i == WB_RDATA)
               wb_dat_o <= rd_reg;
            else if (wb_adr_i == WB_STATUS)
               wb_dat_o <= {27'h0, parErr_reg, ack_reg, state_reg == H_RUN};
            else if (wb_adr_i == WB_IRQ_STAT)
               wb_dat_o <= 32'(irqStat_reg);
            else if (wb_adr_i == WB_IRQ_MASK)
               wb_dat_o <= 32'(irqMask_reg);
            else if (wb_adr_i == WB_WDATA)
               wb_dat_o <= wd_reg;
            else
               wb_dat_o <= 32'h0000_0000;
         end
         // read clears, a new event in the same cycle wins
         if (wbDo && !wb_we_i && wb_adr_i == WB_IRQ_STAT)
            irqStat_reg <= irqSet;
         else
            irqStat_reg <= irqStat_reg | irqSet;
         if (wbDo && wb_we_i && wb_adr_i == WB_IRQ_MASK && wb_sel_i[0])
            irqMask_reg <= wb_dat_i[IRQ_W-1:0];
      end
   end

   assign wb_ack_o        = ack_reg_o;
   assign irq             = |(irqStat_reg & irqMask_reg);
   assign link.linkClk    = clk_reg;
   assign link.dioHost    = out_reg;
   assign link.dioHostOeN = oeN_reg;
endmodule : two_wire_host_ctrl
`default_nettype wire

// ### tb/debug_access_port_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module debug_access_port_asserts
(
   input wire logic clk_sys,    // clock
   input wire logic rstn,       // reset, low
   input wire logic linkClk,    // link clock
   input wire logic dioHost,    // host value
   input wire logic dioHostOeN, // host enable
   input wire logic dioDev,     // device value
   input wire logic dioDevOeN,  // device enable
   input wire logic dio         // data wire
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   one_driver_a: assert property (dioHostOeN || dioDevOeN)
      else $error("both ends drive the wire");
   clk_half_a: assert property ($changed(linkClk) |=>
      $stable(linkClk) [*7] ##1 $changed(linkClk)) else $error("link clock period wrong");
   host_fall_a: assert property (!dioHostOeN && $past(!dioHostOeN) && $changed(dioHost)
      |-> $fell(linkClk)) else $error("host bit moved off a link clock fall");
   turn_gap_a: assert property ($fell(dioDevOeN)
      |-> dioHostOeN && $past(dioHostOeN, 4)) else $error("device drove without turnaround");
   dev_hold_a: assert property (!dioDevOeN && $changed(dioDev)
      |=> $stable(dioDev) [*8]) else $error("device bit too short");
   dev_window_a: assert property ($fell(dioDevOeN)
      |-> !dioDevOeN [*8] ##[24:620] dioDevOeN) else $error("device drive length wrong");
   ack_start_a: assert property ($rose(dioHostOeN) |-> ##[8:14] $fell(dioDevOeN))
      else $error("device did not start the acknowledge after turnaround");
   host_retake_a: assert property ($rose(dioDevOeN) |-> ##[4:22] $fell(dioHostOeN))
      else $error("host did not take the wire back after the device released it");
   cover property ($fell(dioDevOeN));
   cover property ($rose(dioDevOeN));
   cover property ($fell(dioHost) && !dioHostOeN);
endmodule : debug_access_port_asserts
`default_nettype wire

// ### tb/debug_access_port_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
   begin \
      checked++; \
      if ((a) !== (b)) \
      begin \
         errTotal++; \
         $display("[ERR] %0t %h %h", $time, (a), (b)); \
      end \
   end
module debug_access_port_top_tb;
   import debug_access_pkg::*;
   logic        clk_sys, rstn, req, we, ack, irq, wrStb;
   logic [3:0]  c, sel;
   logic [2:0]  stk;
   logic [7:0]  adr, wrSel, wrAddr;
   logic [31:0] dat, rnd, bank, d, wbDo, wrData, e;
   logic [47:0] e2;
   logic [3:0]  cTab[13];
   logic [31:0] v[13];
   logic [31:0] rdQ[$];
   logic [47:0] wrQ[$];
   int          errTotal = 0, checked = 0, cycles = 0;
   two_wire_link_if lnk();
   two_wire_host_ctrl i_two_wire_host_ctrl (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(req),
      .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(wbDo), .wb_ack_o(ack), .irq(irq), .link(lnk.host));
   two_wire_front_port i_two_wire_front_port (.clk_sys(clk_sys), .rstn(rstn), .link(lnk.dev),
      .portWrStb(wrStb), .portWrSel(wrSel), .portWrAddr(wrAddr), .portWrData(wrData),
      .stickyFlags(stk));
   debug_access_port_asserts i_asserts (.clk_sys(clk_sys), .rstn(rstn), .linkClk(lnk.linkClk),
      .dioHost(lnk.dioHost), .dioHostOeN(lnk.dioHostOeN), .dioDev(lnk.dioDev),
      .dioDevOeN(lnk.dioDevOeN), .dio(lnk.dio));
   function automatic logic [31:0] lfsr(input logic [31:0] r);
      return {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
   endfunction : lfsr
   task automatic results();
      $display("compares %0d errors %0d", checked, errTotal);
      if (errTotal == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] x);
      @(posedge clk_sys);
      req <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= x;
      sel <= 4'hF;
      do
         @(negedge clk_sys);
      while (ack !== 1'b1);
      @(posedge clk_sys);
      req <= 1'b0;
      @(negedge clk_sys);
   endtask : wb
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      rdQ.push_back(x);
      wb(1'b0, a, 32'h0);
   endtask : rd
   task automatic go(input logic [3:0] k, input logic [31:0] x);
      int n;
      n = 0;
      wb(1'b1, WB_WDATA, x);
      wb(1'b1, WB_CMD, 32'(k));
      while (irq !== 1'b1 && n < 3000)
      begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 3000)
      begin
         errTotal++;
         results();
      end
   endtask : go
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         errTotal++;
         results();
      end
   end
   always @(negedge clk_sys)
   begin
      if (ack && !we)
      begin
         e = rdQ.pop_front();
         `CHK(wbDo, e)
      end
      if (wrStb)
      begin
         e2 = wrQ.pop_front();
         `CHK({wrSel, wrAddr, wrData}, e2)
      end
   end
   initial
   begin
      rstn = 1'b0;
      req  = 1'b0;
      we   = 1'b0;
      adr  = 8'h00;
      dat  = 32'h0;
      sel  = 4'h0;
      rnd  = 32'h0000_d258;
      bank = 32'h0;
      cTab = '{4'h2, 4'h8, 4'h5, 4'h8, 4'hD, 4'h8, 4'hF, 4'hE, 4'h8, 4'h3, 4'h6, 4'h0, 4'h6};
      v = '{FRONT_ID_CODE, 32'h0100_0020, 32'h0,
         32'h0, 32'h0, 32'h0100_00F0,
         PORT_ID_BASE | 32'h1, PORT_ID_BASE | 32'h1,
         32'h0200_0000, 32'h0, 32'h4, 32'h1, 32'h0};
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      rd(WB_IRQ_MASK, 32'(IRQ_MASK_RST));
      rd(8'h20, 32'h0);
      wb(1'b1, WB_IRQ_MASK, 32'h7);
      rd(WB_IRQ_MASK, 32'h7);
      for (int i = 0; i < 13; i++)
      begin
         rnd = lfsr(rnd);
         c = cTab[i];
         d = c[0] ? rnd : v[i];
         if (c == 4'h8)
            bank = d;
         if (c[0] && !c[1])
            wrQ.push_back({bank[31:24], bank[7:4], c[3:2], 2'b00, d});
         go(c, d);
         if (i == 0)
         begin
            wb(1'b1, WB_IRQ_MASK, 32'h0);
            `CHK(irq, 1'b0)
            wb(1'b1, WB_IRQ_MASK, 32'h7);
            `CHK(irq, 1'b1)
         end
         if (c[1])
            rd(WB_RDATA, v[i]);
         rd(WB_STATUS, 32'h2);
         rd(WB_IRQ_STAT, 32'h1);
         `CHK(irq, 1'b0)
         if (i == 9)
            `CHK(stk, 3'h4)
         if (i == 11)
            `CHK(stk, 3'h0)
      end
      results();
   end
endmodule : debug_access_port_top_tb
`default_nettype wire
